// ==== sgr_params.svh ====
// Offsets, field positions, reset values and timing counts for sleep/reset control
`ifndef SGR_PARAMS_SVH
`define SGR_PARAMS_SVH
`define SGR_OFS_SLEEP_CTRL 8'h33
`define SGR_OFS_MCU_CONTROL 8'h35
`define SGR_OFS_POWER_REDUCTION 8'h64
`define SGR_OFS_STATUS 8'h70
`define SGR_BIT_SLEEP_ALLOW 0
`define SGR_BIT_SLEEP_MODE_LO 1
`define SGR_BIT_BOD_OFF 6
`define SGR_BIT_BOD_UNLOCK 5
`define SGR_BIT_PULLUP_DIS 4
`define SGR_BIT_VEC_SEL 1
`define SGR_BIT_VEC_UNLOCK 0
`define SGR_BIT_PR_RESERVED 4
`define SGR_RST_SLEEP_CTRL 8'h00
`define SGR_RST_MCU_CONTROL 8'h00
`define SGR_RST_POWER_REDUCTION 8'h00
`define SGR_MASK_SLEEP_CTRL 8'h0F
`define SGR_MASK_MCU_CONTROL 8'h13
`define SGR_MASK_POWER_REDUCTION 8'hEF
`define SGR_UNLOCK_WINDOW 4
`define SGR_BOD_ACTIVE_DELAY 3
`define SGR_BOD_ACTIVE_HOLD 3
`define SGR_VEC_UNLOCK_WINDOW 4
`define SGR_TIMEOUT_DEFAULT 64
`endif

// ==== sgr_pkg.sv ====
// Types shared by both ends of the sleep/reset control link
package sgr_pkg;
	typedef enum logic [2:0] {
		SGR_SM_IDLE = 3'h0,
		SGR_SM_NOISE = 3'h1,
		SGR_SM_PDOWN = 3'h2,
		SGR_SM_PSAVE = 3'h3,
		SGR_SM_RES4 = 3'h4,
		SGR_SM_RES5 = 3'h5,
		SGR_SM_STBY = 3'h6,
		SGR_SM_XSTBY = 3'h7
	} sgr_sleep_mode_t;
	typedef enum logic [2:0] {
		SGR_ST_HOLD = 3'b001,
		SGR_ST_DELAY = 3'b010,
		SGR_ST_RUN = 3'b100
	} sgr_rst_state_t;
endpackage

// ==== sgr_link_if.sv ====
// Link between the processor core end and the sleep/reset control end
`timescale 1ns/10ps
interface sgr_link_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic sleep_instr;
	logic sleep_enter;
	sgr_pkg::sgr_sleep_mode_t sleep_mode;
	logic bod_sleep_off;
	logic core_reset;
	modport device (input addr, wdata, wr, rd, sleep_instr,
		output rdata, sleep_enter, sleep_mode, bod_sleep_off, core_reset);
	modport core (output addr, wdata, wr, rd, sleep_instr,
		input rdata, sleep_enter, sleep_mode, bod_sleep_off, core_reset);
endinterface

// ==== sgr_device.sv ====
// Sleep control, brown-out sleep unlock, clock gating and reset sequencing
`timescale 1ns/10ps
`include "sgr_params.svh"
module sgr_device #(
	parameter int TIMEOUT_CYCLES = `SGR_TIMEOUT_DEFAULT
) (
	// Clock, reset, enable
	input wire logic CLK_IN,
	input wire logic NRST_IN,
	input wire logic CE_IN,
	// Core link
	sgr_link_if.device LINK,
	// Reset sources and settings
	input wire logic POWER_ON_LOW_IN,
	input wire logic NRESET_PIN_IN,
	input wire logic WATCHDOG_EXPIRE_IN,
	input wire logic WATCHDOG_RESET_MODE_IN,
	input wire logic BROWNOUT_LOW_IN,
	input wire logic BROWNOUT_ENABLE_IN,
	input wire logic RESET_PIN_DISABLE_SETTING_IN,
	input wire logic [1:0] STARTUP_TIME_SETTING_IN,
	input wire logic TIMER_TWO_ASYNC_SELECT_IN,
	input wire logic CONVERTER_ENABLED_IN,
	// Gating and reset outputs
	output logic GATE_TWOWIRE_CLOCK_OUT,
	output logic GATE_TIMER_TWO_OUT,
	output logic GATE_TIMER_ZERO_OUT,
	output logic GATE_TIMER_ONE_OUT,
	output logic GATE_SERIAL_PERIPH_CLOCK_OUT,
	output logic GATE_SERIAL_PORT_CLOCK_OUT,
	output logic GATE_CONVERTER_OUT,
	output logic COMPARATOR_MUX_BLOCK_OUT,
	output logic PORT_RESET_OUT,
	output logic PULLUP_GLOBAL_DISABLE_OUT,
	output logic VECTOR_TABLE_SELECT_OUT,
	output logic BROWNOUT_DETECTOR_OFF_OUT
);
	import sgr_pkg::*;
	initial begin
		if (TIMEOUT_CYCLES < 4 || TIMEOUT_CYCLES > 65535) $error("TIMEOUT_CYCLES out of range");
	end
	localparam logic [15:0] TOUT = 16'(TIMEOUT_CYCLES);

	logic [7:0] sleep_ctrl;
	logic [7:0] power_reduction;
	logic pullup_global_disable;
	logic vector_table_select;
	logic [2:0] unlock_cnt;
	logic [2:0] vec_unlock_cnt;
	logic bod_off_set;
	logic [2:0] bod_cnt;
	logic bod_active;
	logic reset_req;
	logic internal_reset;
	logic [18:0] delay_cnt;
	logic [18:0] delay_end;
	logic [7:0] mcu_rd;
	sgr_rst_state_t rst_state;
	sgr_rst_state_t next_rst_state;
	logic core_en;

	// Combined request; any source restarts the stretch
	assign reset_req = POWER_ON_LOW_IN
		| (~NRESET_PIN_IN & ~RESET_PIN_DISABLE_SETTING_IN)
		| (WATCHDOG_EXPIRE_IN & WATCHDOG_RESET_MODE_IN)
		| (BROWNOUT_LOW_IN & BROWNOUT_ENABLE_IN)
		| ~NRST_IN;
	// Port reset asserts combinationally from the sources with no clock, and is held by the registered sequencer state
	assign PORT_RESET_OUT = reset_req | internal_reset;

	// Reset sequencer state
	always_comb begin
		next_rst_state = rst_state;
		case (rst_state)
			SGR_ST_HOLD: if (!reset_req) next_rst_state = SGR_ST_DELAY;
			SGR_ST_DELAY: begin
				if (reset_req) next_rst_state = SGR_ST_HOLD;
				else if (delay_cnt == delay_end - 19'h0_0001) next_rst_state = SGR_ST_RUN;
			end
			SGR_ST_RUN: if (reset_req) next_rst_state = SGR_ST_HOLD;
			default: next_rst_state = SGR_ST_HOLD;
		endcase
	end

	// Sequencer is not frozen by the enable so reset always completes
	always_ff @(posedge CLK_IN) begin
		if (reset_req) begin
			rst_state <= SGR_ST_HOLD;
			delay_cnt <= 19'h0_0000;
		end else begin
			rst_state <= next_rst_state;
			// One step per clock while stretching
			if (rst_state == SGR_ST_DELAY)
				delay_cnt <= delay_cnt + 19'h0_0001;
			else
				delay_cnt <= 19'h0_0000;
		end
	end
	// Each start-up setting step doubles the stretch; the parameter is the shortest one
	assign delay_end = {3'h0, TOUT} << STARTUP_TIME_SETTING_IN;
	assign internal_reset = (rst_state != SGR_ST_RUN);
	assign LINK.core_reset = internal_reset;
	assign core_en = CE_IN & ~internal_reset;

	// Sleep control register
	always_ff @(posedge CLK_IN) begin
		if (internal_reset) begin
			sleep_ctrl <= `SGR_RST_SLEEP_CTRL;
		end else if (core_en && LINK.wr && LINK.addr == `SGR_OFS_SLEEP_CTRL) begin
			sleep_ctrl <= LINK.wdata & `SGR_MASK_SLEEP_CTRL;
		end
	end

	// Power reduction register, reserved bit never stored
	always_ff @(posedge CLK_IN) begin
		if (internal_reset) begin
			power_reduction <= `SGR_RST_POWER_REDUCTION;
		end else if (core_en && LINK.wr && LINK.addr == `SGR_OFS_POWER_REDUCTION) begin
			power_reduction <= LINK.wdata & `SGR_MASK_POWER_REDUCTION;
		end
	end

	// Plain control bits and vector-select timed change
	always_ff @(posedge CLK_IN) begin
		if (internal_reset) begin
			pullup_global_disable <= 1'b0;
			vector_table_select <= 1'b0;
			vec_unlock_cnt <= 3'h0;
		end else if (core_en) begin
			if (vec_unlock_cnt != 3'h0) vec_unlock_cnt <= vec_unlock_cnt - 3'h1;
			if (LINK.wr && LINK.addr == `SGR_OFS_MCU_CONTROL) begin
				pullup_global_disable <= LINK.wdata[`SGR_BIT_PULLUP_DIS];
				if (LINK.wdata[`SGR_BIT_VEC_UNLOCK])
					vec_unlock_cnt <= 3'(`SGR_VEC_UNLOCK_WINDOW);
				else if (vec_unlock_cnt != 3'h0)
					vector_table_select <= LINK.wdata[`SGR_BIT_VEC_SEL];
			end
		end
	end

	// Timed unlock for the brown-out sleep-off bit
	always_ff @(posedge CLK_IN) begin
		if (internal_reset) begin
			unlock_cnt <= 3'h0;
			bod_off_set <= 1'b0;
			bod_cnt <= 3'h0;
			bod_active <= 1'b0;
		end else if (core_en) begin
			if (unlock_cnt != 3'h0) unlock_cnt <= unlock_cnt - 3'h1;
			if (LINK.wr && LINK.addr == `SGR_OFS_MCU_CONTROL && LINK.wdata[`SGR_BIT_BOD_OFF]
				&& LINK.wdata[`SGR_BIT_BOD_UNLOCK]) begin
				unlock_cnt <= 3'(`SGR_UNLOCK_WINDOW);
			end else if (LINK.wr && LINK.addr == `SGR_OFS_MCU_CONTROL && unlock_cnt != 3'h0
				&& LINK.wdata[`SGR_BIT_BOD_OFF] && !bod_off_set) begin
				bod_off_set <= 1'b1;
				bod_cnt <= 3'h0;
				unlock_cnt <= 3'h0;
			end
			// Count to activation, then hold active, then clear
			if (bod_off_set) begin
				bod_cnt <= bod_cnt + 3'h1;
				if (!bod_active && bod_cnt == 3'(`SGR_BOD_ACTIVE_DELAY - 1)) begin
					bod_active <= 1'b1;
					bod_cnt <= 3'h0;
				end else if (bod_active && bod_cnt == 3'(`SGR_BOD_ACTIVE_HOLD - 1)) begin
					bod_active <= 1'b0;
					bod_off_set <= 1'b0;
					bod_cnt <= 3'h0;
				end
			end
		end
	end

	// Sleep entry and detector shutdown flag
	always_ff @(posedge CLK_IN) begin
		if (internal_reset) begin
			LINK.sleep_enter <= 1'b0;
			BROWNOUT_DETECTOR_OFF_OUT <= 1'b0;
		end else if (core_en) begin
			LINK.sleep_enter <= LINK.sleep_instr & sleep_ctrl[`SGR_BIT_SLEEP_ALLOW];
			// Held through the sleep; the device cannot see the wake, so the
			// core's first write after waking ends it
			if (LINK.sleep_instr && sleep_ctrl[`SGR_BIT_SLEEP_ALLOW])
				BROWNOUT_DETECTOR_OFF_OUT <= bod_active;
			else if (LINK.wr)
				BROWNOUT_DETECTOR_OFF_OUT <= 1'b0;
		end
	end
	assign LINK.sleep_mode = sgr_sleep_mode_t'(sleep_ctrl[3:1]);
	assign LINK.bod_sleep_off = bod_active;

	// Read path, data one cycle after the strobe
	always_comb begin
		mcu_rd = {1'b0, bod_off_set, 1'b0, pullup_global_disable, 2'b00, vector_table_select, 1'b0};
	end
	always_ff @(posedge CLK_IN) begin
		if (internal_reset) begin
			LINK.rdata <= 8'h00;
		end else if (core_en) begin
			if (!LINK.rd) LINK.rdata <= 8'h00;
			else case (LINK.addr)
				`SGR_OFS_SLEEP_CTRL: LINK.rdata <= sleep_ctrl;
				`SGR_OFS_MCU_CONTROL: LINK.rdata <= mcu_rd;
				`SGR_OFS_POWER_REDUCTION: LINK.rdata <= power_reduction;
				default: LINK.rdata <= 8'h00;
			endcase
		end
	end

	// Gating outputs from the stored register bits
	assign GATE_TWOWIRE_CLOCK_OUT = power_reduction[7];
	assign GATE_TIMER_TWO_OUT = power_reduction[6] & ~TIMER_TWO_ASYNC_SELECT_IN;
	assign GATE_TIMER_ZERO_OUT = power_reduction[5];
	assign GATE_TIMER_ONE_OUT = power_reduction[3];
	assign GATE_SERIAL_PERIPH_CLOCK_OUT = power_reduction[2];
	assign GATE_SERIAL_PORT_CLOCK_OUT = power_reduction[1];
	// Converter shut only once disabled, so a live conversion is not cut
	assign GATE_CONVERTER_OUT = power_reduction[0] & ~CONVERTER_ENABLED_IN;
	assign COMPARATOR_MUX_BLOCK_OUT = GATE_CONVERTER_OUT;
	assign PULLUP_GLOBAL_DISABLE_OUT = pullup_global_disable;
	assign VECTOR_TABLE_SELECT_OUT = vector_table_select;
endmodule

// ==== sgr_core.sv ====
// Core end: runs software register accesses and sleep instructions
`timescale 1ns/10ps
`include "sgr_params.svh"
module sgr_core (
	// Clock, reset, enable
	input wire logic CLK_IN,
	input wire logic NRST_IN,
	input wire logic CE_IN,
	// Link to the device
	sgr_link_if.core LINK,
	// User command port
	input wire logic [7:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	input wire logic SLEEP_IN,
	input wire logic BOD_SLEEP_IN,
	input wire logic WAKE_IN,
	output logic [7:0] RDATA_OUT,
	output logic ASLEEP_OUT,
	output logic BUSY_OUT
);
	import sgr_pkg::*;
	logic [2:0] seq;
	logic [7:0] mode_bits;
	logic [1:0] pause;
	// Drive link; sequences set allow just before sleep
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN || LINK.core_reset) begin
			LINK.addr <= 8'h00;
			LINK.wdata <= 8'h00;
			LINK.wr <= 1'b0;
			LINK.rd <= 1'b0;
			LINK.sleep_instr <= 1'b0;
			seq <= 3'h0;
			mode_bits <= 8'h00;
			pause <= 2'h0;
			ASLEEP_OUT <= 1'b0;
		end else if (CE_IN) begin
			LINK.wr <= 1'b0;
			LINK.rd <= 1'b0;
			LINK.sleep_instr <= 1'b0;
			case (seq)
				3'h0: begin
					if (SLEEP_IN || BOD_SLEEP_IN) begin
						// Bit 0 carries the allow bit, so a refused sleep can be tried
						mode_bits <= WDATA_IN & 8'h0F;
						seq <= BOD_SLEEP_IN ? 3'h1 : 3'h3;
					end else begin
						LINK.addr <= ADDR_IN;
						LINK.wdata <= WDATA_IN;
						LINK.wr <= WR_IN;
						LINK.rd <= RD_IN & ~WR_IN;
					end
					if (ASLEEP_OUT && WAKE_IN) begin
						ASLEEP_OUT <= 1'b0;
						LINK.addr <= `SGR_OFS_SLEEP_CTRL;
						LINK.wdata <= mode_bits & 8'h0E;
						LINK.wr <= 1'b1;
						LINK.rd <= 1'b0;
					end
				end
				3'h1: begin
					LINK.addr <= `SGR_OFS_MCU_CONTROL;
					LINK.wdata <= 8'h60;
					LINK.wr <= 1'b1;
					seq <= 3'h2;
				end
				3'h2: begin
					LINK.wdata <= 8'h40;
					LINK.wr <= 1'b1;
					// Puts the instruction in the middle of the three active cycles
					pause <= 2'(`SGR_BOD_ACTIVE_DELAY);
					seq <= 3'h3;
				end
				3'h3: begin
					LINK.addr <= `SGR_OFS_SLEEP_CTRL;
					LINK.wdata <= mode_bits;
					LINK.wr <= 1'b1;
					seq <= 3'h4;
				end
				3'h4: begin
					if (pause != 2'h0) begin
						pause <= pause - 2'h1;
					end else begin
						LINK.sleep_instr <= 1'b1;
						seq <= 3'h5;
					end
				end
				// The answer is registered, so it is read one edge later
				3'h5: seq <= 3'h6;
				3'h6: begin
					ASLEEP_OUT <= LINK.sleep_enter;
					seq <= 3'h0;
				end
				default: seq <= 3'h0;
			endcase
		end
	end
	assign RDATA_OUT = LINK.rdata;
	assign BUSY_OUT = (seq != 3'h0);
endmodule

// ==== sgr_link_checker.sv ====
// Link checks between the core end and the device end
`timescale 1ns/10ps
module sgr_link_checker #(
	parameter int TIMEOUT_CYCLES = 64
) (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic NRST_IN,
	// Link signals
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic sleep_instr,
	input wire logic sleep_enter,
	input sgr_pkg::sgr_sleep_mode_t sleep_mode,
	input wire logic bod_sleep_off,
	input wire logic core_reset
);
	import sgr_pkg::*;
	logic allow;
	logic [2:0] mode;
	logic [7:0] pr;
	logic [4:0] since_unlock;
	logic [7:0] hi_cnt;
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!NRST_IN);
	// Shadow of written state; writes under internal reset are refused
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN || core_reset) begin
			allow <= 1'b0;
			mode <= 3'h0;
			pr <= 8'h00;
		end else if (wr && addr == 8'h33) begin
			allow <= wdata[0];
			mode <= wdata[3:1];
		end else if (wr && addr == 8'h64) begin
			pr <= wdata & 8'hEF;
		end
	end
	// Age of the last unlock write, saturating so it never wraps back
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN || (wr && addr == 8'h35 && wdata[6:5] == 2'b11)) begin
			since_unlock <= 5'h00;
		end else if (since_unlock != 5'h1F) begin
			since_unlock <= since_unlock + 5'h01;
		end
	end
	// Length of the current internal reset after the bench reset lifted
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN || !core_reset) begin
			hi_cnt <= 8'h00;
		end else if (hi_cnt != 8'hFF) begin
			hi_cnt <= hi_cnt + 8'h01;
		end
	end
	a_sleep_allowed: assert property (sleep_instr && !core_reset && allow |=> sleep_enter)
		else $error("sleep refused with allow set");
	a_sleep_blocked: assert property (sleep_instr && !allow |=> !sleep_enter)
		else $error("sleep taken with allow clear");
	a_enter_cause: assert property (sleep_enter |-> $past(sleep_instr))
		else $error("sleep entry without instruction");
	a_mode_live: assert property (!core_reset |-> sleep_mode == mode)
		else $error("sleep mode differs from written field");
	a_ctrl_readback: assert property (rd && !core_reset && addr == 8'h33
		|=> rdata == {4'h0, mode, allow})
		else $error("sleep control readback wrong");
	a_gate_readback: assert property (rd && !core_reset && addr == 8'h64 |=> rdata == pr)
		else $error("power reduction readback wrong");
	a_reserved_zero: assert property (rd && addr == 8'h64 |=> !rdata[4])
		else $error("reserved bit reads one");
	a_unlock_needed: assert property (rd && !core_reset && addr == 8'h35
		&& since_unlock > 5'h0C |=> !rdata[6])
		else $error("off bit seen without recent unlock");
	a_delay_stretch: assert property ($fell(core_reset) |-> hi_cnt >= TIMEOUT_CYCLES)
		else $error("internal reset released too early");
	a_off_delay: assert property ((wr && addr == 8'h35 && wdata[6:5] == 2'b11) ##1 (wr
		&& addr == 8'h35 && wdata[6:5] == 2'b10) |=> ##2 !bod_sleep_off ##1 bod_sleep_off)
		else $error("off bit not active three cycles after set");
	a_off_clear: assert property ($rose(bod_sleep_off)
		|-> bod_sleep_off[*3] ##1 !bod_sleep_off)
		else $error("off bit not cleared after three active cycles");
endmodule

// ==== tb_sleep_gating_reset_control.sv ====
// Bench joining the core end and the device end over the link
`timescale 1ns/10ps
module tb_sleep_gating_reset_control;
	import sgr_pkg::*;
	localparam int TMO = 4;
	// Clock, reset sources and settings
	logic clk = 1'b0, nrst = 1'b0, por = 1'b0, npin = 1'b1, wdx = 1'b0, wdm = 1'b0;
	logic bol = 1'b0, boe = 1'b1, pdis = 1'b0, t2a = 1'b0, cen = 1'b0;
	// Core user port
	logic [7:0] addr = 8'h00, wdata = 8'h00, p;
	logic wr = 1'b0, rd = 1'b0, slp = 1'b0, bslp = 1'b0, wake = 1'b0;
	wire [7:0] rdata, g;
	wire asleep, busy, prst, bodoff, pud_o, vts_o;
	int fails = 0, check_count = 0, i, n;
	sgr_link_if link();
	wire [3:0] mon = {busy, link.core_reset, bodoff, asleep};
	always #4 clk = ~clk;
	sgr_core sgr_core_i(.CLK_IN(clk), .NRST_IN(nrst), .CE_IN(1'b1), .LINK(link),
		.ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .SLEEP_IN(slp),
		.BOD_SLEEP_IN(bslp), .WAKE_IN(wake), .RDATA_OUT(rdata), .ASLEEP_OUT(asleep),
		.BUSY_OUT(busy));
	sgr_device #(.TIMEOUT_CYCLES(TMO)) sgr_device_i(.CLK_IN(clk), .NRST_IN(nrst),
		.CE_IN(1'b1), .LINK(link), .POWER_ON_LOW_IN(por), .NRESET_PIN_IN(npin),
		.WATCHDOG_EXPIRE_IN(wdx), .WATCHDOG_RESET_MODE_IN(wdm), .BROWNOUT_LOW_IN(bol),
		.BROWNOUT_ENABLE_IN(boe), .RESET_PIN_DISABLE_SETTING_IN(pdis),
		.STARTUP_TIME_SETTING_IN(2'b00), .TIMER_TWO_ASYNC_SELECT_IN(t2a),
		.CONVERTER_ENABLED_IN(cen), .GATE_TWOWIRE_CLOCK_OUT(g[7]), .GATE_TIMER_TWO_OUT(g[6]),
		.GATE_TIMER_ZERO_OUT(g[5]), .COMPARATOR_MUX_BLOCK_OUT(g[4]), .GATE_TIMER_ONE_OUT(g[3]),
		.GATE_SERIAL_PERIPH_CLOCK_OUT(g[2]), .GATE_SERIAL_PORT_CLOCK_OUT(g[1]),
		.GATE_CONVERTER_OUT(g[0]), .PORT_RESET_OUT(prst), .PULLUP_GLOBAL_DISABLE_OUT(pud_o),
		.VECTOR_TABLE_SELECT_OUT(vts_o), .BROWNOUT_DETECTOR_OFF_OUT(bodoff));
	sgr_link_checker #(.TIMEOUT_CYCLES(TMO)) sgr_link_checker_i(.CLK_IN(clk), .NRST_IN(nrst),
		.addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
		.sleep_instr(link.sleep_instr), .sleep_enter(link.sleep_enter),
		.sleep_mode(link.sleep_mode), .bod_sleep_off(link.bod_sleep_off),
		.core_reset(link.core_reset));
	// Gate levels expected from a register value and the two qualifiers
	function automatic logic [7:0] gexp(input logic [7:0] r);
		return {r[7], r[6] & ~t2a, r[5], r[0] & ~cen, r[3], r[2], r[1], r[0] & ~cen};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Bounded wait on one monitored flag; the count is left in n
	task automatic wait_for(input int s, input logic v);
		#1;
		for (n = 0; n < 80 && mon[s] !== v; n++) begin
			@(posedge clk);
			#1;
		end
		if (n == 80) begin
			fails++;
			finish_test();
		end
	endtask
	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	// Read data lands two edges after the request, one hop per end
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		#1;
		chk(rdata, e);
	endtask
	task automatic sleep_run(input logic [7:0] d, input logic b);
		wdata <= d;
		slp <= !b;
		bslp <= b;
		@(posedge clk);
		slp <= 1'b0;
		bslp <= 1'b0;
		wait_for(0, 1'b1);
	endtask
	task automatic wake_up();
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		wait_for(0, 1'b0);
		wait_for(3, 1'b0);
	endtask
	// Cases 0..3 are live sources, 4..6 are sources 2, 3 and 1 disqualified
	task automatic set_src(input int k, input logic v);
		por <= v && k == 0;
		npin <= !(v && (k == 1 || k == 6));
		wdx <= v && (k == 2 || k == 4);
		wdm <= k == 2;
		bol <= v && (k == 3 || k == 5);
		boe <= k != 5;
		pdis <= k == 6;
	endtask
	initial begin
		void'($urandom(32'h29f8_811f));
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		wait_for(2, 1'b0);
		chk(8'(n >= TMO), 8'h01);
		rd_chk(8'h33, 8'h00);
		rd_chk(8'h35, 8'h00);
		rd_chk(8'h64, 8'h00);
		rd_chk(8'h20, 8'h00);
		$display("test reset values done");
		for (i = 0; i < 10; i++) begin
			p = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
			t2a <= 1'($urandom);
			cen <= 1'($urandom);
			bus_wr(8'h64, p);
			rd_chk(8'h64, p & 8'hEF);
			chk(g, gexp(p));
		end
		$display("test clock gating done");
		for (i = 0; i < 8; i++) begin
			sleep_run({4'h0, 3'(i), 1'b1}, 1'b0);
			chk({5'h00, link.sleep_mode}, 8'(i));
			chk({7'h00, bodoff}, 8'h00);
			wake_up();
			rd_chk(8'h33, 8'(i * 2));
		end
		// Allow bit left clear: the instruction must be ignored
		wdata <= 8'h04;
		slp <= 1'b1;
		@(posedge clk);
		slp <= 1'b0;
		wait_for(3, 1'b0);
		chk({7'h00, asleep}, 8'h00);
		chk({7'h00, bodoff}, 8'h00);
		rd_chk(8'h33, 8'h04);
		$display("test sleep modes done");
		bus_wr(8'h35, 8'h60);
		bus_wr(8'h35, 8'h40);
		rd_chk(8'h35, 8'h40);
		repeat (12) @(posedge clk);
		rd_chk(8'h35, 8'h00);
		bus_wr(8'h35, 8'h40);
		rd_chk(8'h35, 8'h00);
		sleep_run(8'h05, 1'b1);
		wait_for(1, 1'b1);
		chk({7'h00, bodoff}, 8'h01);
		wake_up();
		repeat (2) @(posedge clk);
		#1;
		chk({7'h00, bodoff}, 8'h00);
		$display("test detector off done");
		// Pull-up disable and the timed vector-select change
		bus_wr(8'h35, 8'h11);
		bus_wr(8'h35, 8'h12);
		rd_chk(8'h35, 8'h12);
		chk({6'h00, pud_o, vts_o}, 8'h03);
		$display("test control bits done");
		for (i = 0; i < 7; i++) begin
			bus_wr(8'h64, 8'h2A);
			set_src(i, 1'b1);
			#1;
			chk({7'h00, prst}, 8'(i < 4));
			repeat (3) @(posedge clk);
			set_src(i, 1'b0);
			wait_for(2, 1'b0);
			chk(8'(n >= TMO || i > 3), 8'h01);
			rd_chk(8'h64, (i < 4) ? 8'h00 : 8'h2A);
		end
		$display("test reset sources done");
		finish_test();
	end
endmodule
